// ===== rtl/zcd_pkg.sv
// Package of register map, field positions and reset values for the zero-cross detector
package zcd_pkg;
    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] ZCD_CONTROL_IDX = 12'h21f;
    localparam logic [11:0] ZCD_STATUS_IDX = 12'h220;
    localparam logic [11:0] ZCD_IRQ_EN_IDX = 12'h221;
    localparam logic [11:0] ZCD_IRQ_CLR_IDX = 12'h222;
    localparam logic [11:0] ZCD_SYS_IDX = 12'h223;
    localparam logic [13:0] ZCD_CONTROL_ADDR = {ZCD_CONTROL_IDX, 2'b00};
    localparam logic [13:0] ZCD_STATUS_ADDR = {ZCD_STATUS_IDX, 2'b00};
    localparam logic [13:0] ZCD_IRQ_EN_ADDR = {ZCD_IRQ_EN_IDX, 2'b00};
    localparam logic [13:0] ZCD_IRQ_CLR_ADDR = {ZCD_IRQ_CLR_IDX, 2'b00};
    localparam logic [13:0] ZCD_SYS_ADDR = {ZCD_SYS_IDX, 2'b00};

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int ZCD_SEN_BIT = 7;
    localparam int ZCD_OUT_BIT = 5;
    localparam int ZCD_POL_BIT = 4;
    localparam int ZCD_RISE_BIT = 1;
    localparam int ZCD_FALL_BIT = 0;
    localparam logic [7:0] ZCD_CONTROL_WMASK = 8'h93;

    // ------------------------------------------------------------------
    // Status, enable and system fields
    // ------------------------------------------------------------------
    localparam int ZCD_FLAG_BIT = 0;
    localparam int ZCD_MD_BIT = 0;
    localparam int ZCD_LOW_BIT = 1;
    localparam int ZCD_GIE_BIT = 2;

    // ------------------------------------------------------------------
    // Reset values and synchroniser depth
    // ------------------------------------------------------------------
    localparam logic [7:0] ZCD_CONTROL_RST = 8'h00;
    localparam logic ZCD_FLAG_RST = 1'b0;
    localparam logic ZCD_IRQ_EN_RST = 1'b0;
    localparam logic [2:0] ZCD_SYS_RST = 3'h0;
    localparam int ZCD_SYNC_STAGES = 3;
endpackage

// ===== rtl/zcd_sync.sv
// Three-stage synchroniser for the asynchronous comparator decision
`timescale 1ns/1ps
module zcd_sync
    import zcd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);
    logic [ZCD_SYNC_STAGES-1:0] chain_q;

    // ------------------------------------------------------------------
    // Shift chain
    // ------------------------------------------------------------------
    // First stage feeds only the second; change accepted when 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_q <= '0;
        end else begin
            chain_q <= {chain_q[ZCD_SYNC_STAGES-2:0], async_in};
        end
    end

    logic stable_q;
    wire agree = (chain_q[1] == chain_q[2]);

    // Hold last agreed value so a half-settled sample cannot glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_q <= 1'b0;
        end else if (agree) begin
            stable_q <= chain_q[2];
        end
    end

    assign sync_out = stable_q;
endmodule

// ===== rtl/zcd_edge.sv
// Rising and falling edge detector producing one-cycle pulses
`timescale 1ns/1ps
module zcd_edge (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic level_in,
    output logic rise_pulse,
    output logic fall_pulse
);
    logic prev_q;

    // ------------------------------------------------------------------
    // Previous value
    // ------------------------------------------------------------------
    // Previous sample of the post-polarity level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level_in;
        end
    end

    // Compare current with previous
    assign rise_pulse = level_in & ~prev_q;
    assign fall_pulse = ~level_in & prev_q;
endmodule

// ===== rtl/zcd_top.sv
// Zero-cross detector digital logic with APB register slave
//
// Functional notes
// - Comparator high drives pin sink; low drives pin source.
// - Without inversion, cross_level reads one while sink active.
// - polarity_invert set inverts cross_level.
// - Edge detection uses the post-polarity logic output.
// - Separate rise and fall detectors set cross_irq_flag when enabled.
// - rise_irq_enable and fall_irq_enable gate their edges independently.
// - Interrupt needs flag, flag enable, low and global enables.
// - Changing polarity_invert makes an edge regardless of soft_enable.
// - Software clears the flag; a coincident enabled edge keeps it set.
// - Source, sink and edge interrupts run unchanged in sleep.
// - Fuse zero: detector always enabled, soft_enable ignored.
// - Fuse one: once captured after reset, soft_enable enables detector, else pin control returns.
// - module_disable also disables, only when fuse permits.
// - Logic output offered to other peripherals as a selectable input.
// - Rise enable one: low-to-high sets flag; zero leaves it.
`timescale 1ns/1ps
module zcd_top
    import zcd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic config_fuse,
    input wire logic comparator_above,
    input wire logic sleep_mode,
    output logic pin_sink_en,
    output logic pin_source_en,
    output logic pin_force_analog,
    output logic detector_active,
    output logic cross_level_out,
    output logic irq
);
    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic soft_enable_q;
    logic polarity_invert_q;
    logic rise_irq_enable_q;
    logic fall_irq_enable_q;
    logic cross_irq_flag_q;
    logic cross_irq_flag_d;
    logic cross_irq_enable_q;
    logic module_disable_q;
    logic low_irq_enable_q;
    logic global_irq_enable_q;
    logic fuse_q;
    logic fuse_seen_q;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire [13:0] word_addr = paddr[13:0];
    wire addr_hi_zero = (paddr[31:14] == 18'h0) && (paddr[1:0] == 2'b00);
    wire hit_ctrl = addr_hi_zero && (word_addr == ZCD_CONTROL_ADDR);
    wire hit_stat = addr_hi_zero && (word_addr == ZCD_STATUS_ADDR);
    wire hit_en = addr_hi_zero && (word_addr == ZCD_IRQ_EN_ADDR);
    wire hit_clr = addr_hi_zero && (word_addr == ZCD_IRQ_CLR_ADDR);
    wire hit_sys = addr_hi_zero && (word_addr == ZCD_SYS_ADDR);
    wire mapped = hit_ctrl | hit_stat | hit_en | hit_clr | hit_sys;
    wire access = psel & penable;
    wire wr_lane0 = access & pwrite & pstrb[0] & mapped;
    wire wr_ctrl = wr_lane0 & hit_ctrl;
    wire wr_en = wr_lane0 & hit_en;
    wire wr_clr = wr_lane0 & hit_clr;
    wire wr_sys = wr_lane0 & hit_sys;

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // ------------------------------------------------------------------
    // Fuse capture after reset release
    // ------------------------------------------------------------------
    // Strap is sampled by a clocked process, never loaded by the reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_q <= 1'b0;
            fuse_seen_q <= 1'b0;
        end else if (!fuse_seen_q) begin
            fuse_q <= config_fuse;
            fuse_seen_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Enable logic
    // ------------------------------------------------------------------
    // Fuse clear: always on, soft_enable and module_disable are ignored
    wire fuse_forces_on = ~fuse_q;
    wire sw_enabled = soft_enable_q & ~module_disable_q;
    assign detector_active = fuse_forces_on | sw_enabled;
    assign pin_force_analog = detector_active;
    // Sleep input is deliberately unused in gating: operation continues
    wire sleep_ignored = sleep_mode & 1'b0;

    // ------------------------------------------------------------------
    // Comparator path
    // ------------------------------------------------------------------
    logic comp_sync;

    zcd_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(comparator_above),
        .sync_out(comp_sync)
    );

    // Sink above the reference, source below it, only while active
    assign pin_sink_en = detector_active & comp_sync;
    assign pin_source_en = detector_active & ~comp_sync;

    // Polarity applied ahead of the edge detectors, so a polarity write
    // itself flips the level and can raise the flag even when disabled
    wire cross_level = comp_sync ^ polarity_invert_q ^ sleep_ignored;
    assign cross_level_out = cross_level;

    // ------------------------------------------------------------------
    // Edge detection and flag
    // ------------------------------------------------------------------
    logic rise_pulse;
    logic fall_pulse;

    zcd_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level_in(cross_level),
        .rise_pulse(rise_pulse),
        .fall_pulse(fall_pulse)
    );

    wire edge_set = (rise_pulse & rise_irq_enable_q)
        | (fall_pulse & fall_irq_enable_q);
    wire flag_clear = wr_clr & pwdata[ZCD_FLAG_BIT];

    // Set wins over a coincident clear
    always_comb begin
        cross_irq_flag_d = cross_irq_flag_q;
        if (flag_clear) begin
            cross_irq_flag_d = 1'b0;
        end
        if (edge_set) begin
            cross_irq_flag_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cross_irq_flag_q <= ZCD_FLAG_RST;
        end else begin
            cross_irq_flag_q <= cross_irq_flag_d;
        end
    end

    // Request needs every enable in the chain
    assign irq = cross_irq_flag_q & cross_irq_enable_q
        & low_irq_enable_q & global_irq_enable_q;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_enable_q <= ZCD_CONTROL_RST[ZCD_SEN_BIT];
            polarity_invert_q <= ZCD_CONTROL_RST[ZCD_POL_BIT];
            rise_irq_enable_q <= ZCD_CONTROL_RST[ZCD_RISE_BIT];
            fall_irq_enable_q <= ZCD_CONTROL_RST[ZCD_FALL_BIT];
        end else if (wr_ctrl) begin
            soft_enable_q <= pwdata[ZCD_SEN_BIT];
            polarity_invert_q <= pwdata[ZCD_POL_BIT];
            rise_irq_enable_q <= pwdata[ZCD_RISE_BIT];
            fall_irq_enable_q <= pwdata[ZCD_FALL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cross_irq_enable_q <= ZCD_IRQ_EN_RST;
        end else if (wr_en) begin
            cross_irq_enable_q <= pwdata[ZCD_FLAG_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_disable_q <= ZCD_SYS_RST[ZCD_MD_BIT];
            low_irq_enable_q <= ZCD_SYS_RST[ZCD_LOW_BIT];
            global_irq_enable_q <= ZCD_SYS_RST[ZCD_GIE_BIT];
        end else if (wr_sys) begin
            module_disable_q <= pwdata[ZCD_MD_BIT];
            low_irq_enable_q <= pwdata[ZCD_LOW_BIT];
            global_irq_enable_q <= pwdata[ZCD_GIE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    wire [7:0] ctrl_rd = ZCD_CONTROL_WMASK
        & {soft_enable_q, 2'b00, polarity_invert_q, 2'b00,
           rise_irq_enable_q, fall_irq_enable_q};
    wire [7:0] ctrl_view = ctrl_rd | ({7'h0, cross_level} << ZCD_OUT_BIT);
    wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_view}
        : hit_stat ? {31'h0, cross_irq_flag_q}
        : hit_en ? {31'h0, cross_irq_enable_q}
        : hit_sys ? {29'h0, global_irq_enable_q, low_irq_enable_q, module_disable_q}
        : 32'h0;

    // Read data registered at the setup edge so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= rd_mux;
        end
    end
endmodule

// ===== test/zcd_ac_source.sv
// Behavioural AC source seen by the comparator through the series resistor
`timescale 1ns/1ps
module zcd_ac_source (
    input wire logic above_req,
    input wire logic slow,
    output logic comparator_above
);
    // Decision lags the request off the clock grid; slow mimics a shallow slope
    initial comparator_above = 1'b0;
    always @(above_req) begin
        comparator_above <= #(slow ? 27 : 3) above_req;
    end
endmodule

// ===== test/zcd_top_sva.sv
// Concurrent checks on the zero-cross detector ports
`timescale 1ns/1ps
module zcd_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic comparator_above,
    input wire logic pin_sink_en,
    input wire logic pin_source_en,
    input wire logic pin_force_analog,
    input wire logic detector_active,
    input wire logic cross_level_out,
    input wire logic irq
);
    // --------------------------------------------------------------
    // Pin drive
    // --------------------------------------------------------------
    AST_SINK: assert property (@(posedge pclk) disable iff (!presetn)
        (comparator_above && detector_active)[*7] |-> pin_sink_en && !pin_source_en)
        else $error("sink not active for a settled high decision");
    AST_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
        (!comparator_above && detector_active)[*7] |-> pin_source_en && !pin_sink_en)
        else $error("source not active for a settled low decision");
    AST_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !detector_active |-> !pin_sink_en && !pin_source_en)
        else $error("pin driven while detector disabled");
    AST_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
        pin_force_analog == detector_active)
        else $error("pin forcing differs from detector enable");
    // --------------------------------------------------------------
    // Interrupt and bus
    // --------------------------------------------------------------
    // Irq may only rise after a level edge or a register write
    AST_IRQ_RISE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(irq) |-> ($past(cross_level_out, 1) != $past(cross_level_out, 2))
        || $past(psel && penable && pwrite))
        else $error("irq rose without an edge or a write");
    AST_IRQ_FALL: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(irq) |-> $past(psel && penable && pwrite))
        else $error("irq dropped without a software write");
    AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable |-> pready)
        else $error("access phase not answered at once");
    AST_SLVERR: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> psel && penable)
        else $error("error response outside an access phase");
endmodule
bind zcd_top zcd_top_sva i_zcd_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .comparator_above(comparator_above), .pin_sink_en(pin_sink_en),
    .pin_source_en(pin_source_en), .pin_force_analog(pin_force_analog),
    .detector_active(detector_active), .cross_level_out(cross_level_out), .irq(irq));

// ===== test/zcd_top_bench.sv
// Self-checking bench for the zero-cross detector logic
`timescale 1ns/1ps
module zcd_top_bench;
    import zcd_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, fuse, above_req, sleep, slow, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic pready, pslverr, sink, source, force_an, active, level, irq, above;
    int n_mismatch = 0;
    int compares = 0;
    zcd_top i_zcd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .config_fuse(fuse), .comparator_above(above),
        .sleep_mode(sleep), .pin_sink_en(sink), .pin_source_en(source),
        .pin_force_analog(force_an), .detector_active(active),
        .cross_level_out(level), .irq(irq));
    zcd_ac_source i_zcd_ac_source (.above_req(above_req), .slow(slow),
        .comparator_above(above));
    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {18'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    // Move the source, then allow the synchroniser to settle
    task automatic drive(input logic v);
        @(posedge pclk);
        above_req <= v;
        repeat (12) @(posedge pclk);
        @(negedge pclk);
    endtask
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_regs();
        apb(0, ZCD_CONTROL_ADDR, 0);
        chk(rd & 32'h93, 32'h0);
        apb(0, ZCD_STATUS_ADDR, 0);
        chk(rd, 32'h0);
        apb(0, ZCD_IRQ_EN_ADDR, 0);
        chk(rd, 32'h0);
        apb(0, ZCD_SYS_ADDR, 0);
        chk(rd, 32'h0);
        apb(0, 14'h0004, 0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask
    task automatic t_level();
        drive(1'b0);
        chk({sink, source, level}, 3'b010);
        drive(1'b1);
        chk({sink, source, level}, 3'b101);
        apb(0, ZCD_CONTROL_ADDR, 0);
        chk(rd[5], 1'b1);
        apb(1, ZCD_CONTROL_ADDR, 32'h10);
        chk({sink, level}, 2'b10);
        apb(1, ZCD_CONTROL_ADDR, 32'h00);
        chk(level, 1'b1);
    endtask
    // Edges under sleep and a slow source; polarity decides the direction
    task automatic t_edges();
        @(posedge pclk);
        sleep <= 1'b1;
        slow <= 1'b1;
        apb(1, ZCD_CONTROL_ADDR, 32'h02);
        drive(1'b0);
        apb(0, ZCD_STATUS_ADDR, 0);
        chk(rd, 32'h0);
        drive(1'b1);
        apb(0, ZCD_STATUS_ADDR, 0);
        chk(rd, 32'h1);
        apb(1, ZCD_IRQ_CLR_ADDR, 32'h1);
        apb(1, ZCD_CONTROL_ADDR, 32'h12);
        apb(0, ZCD_STATUS_ADDR, 0);
        chk(rd, 32'h0);
        drive(1'b0);
        apb(0, ZCD_STATUS_ADDR, 0);
        chk(rd, 32'h1);
        apb(1, ZCD_IRQ_CLR_ADDR, 32'h1);
        apb(1, ZCD_CONTROL_ADDR, 32'h11);
        drive(1'b1);
        apb(0, ZCD_STATUS_ADDR, 0);
        chk(rd, 32'h1);
        apb(1, ZCD_CONTROL_ADDR, 32'h00);
        apb(1, ZCD_IRQ_CLR_ADDR, 32'h1);
        @(posedge pclk);
        sleep <= 1'b0;
        slow <= 1'b0;
    endtask
    // Clear write lands on the same edge as an enabled falling level edge
    task automatic t_clash();
        apb(1, ZCD_CONTROL_ADDR, 32'h03);
        @(posedge pclk);
        above_req <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(level, 1'b1);
        apb(1, ZCD_IRQ_CLR_ADDR, 32'h1);
        apb(0, ZCD_STATUS_ADDR, 0);
        chk(rd, 32'h1);
        apb(1, ZCD_CONTROL_ADDR, 32'h00);
        drive(1'b1);
        apb(1, ZCD_IRQ_CLR_ADDR, 32'h1);
        apb(0, ZCD_STATUS_ADDR, 0);
        chk(rd, 32'h0);
    endtask
    task automatic t_irq();
        apb(1, ZCD_CONTROL_ADDR, 32'h13);
        apb(0, ZCD_STATUS_ADDR, 0);
        chk(rd, 32'h1);
        for (int i = 0; i < 8; i++) begin
            apb(1, ZCD_IRQ_EN_ADDR, {31'h0, i[0]});
            apb(1, ZCD_SYS_ADDR, {29'h0, i[2:1], 1'b0});
            chk(irq, i == 7);
        end
        apb(1, ZCD_IRQ_CLR_ADDR, 32'h1);
        chk(irq, 1'b0);
        apb(1, ZCD_SYS_ADDR, 32'h0);
        apb(1, ZCD_IRQ_EN_ADDR, 32'h0);
        apb(1, ZCD_CONTROL_ADDR, 32'h00);
    endtask
    // Fuse is only taken after reset, so the strapped case runs last
    task automatic t_fuse();
        apb(1, ZCD_SYS_ADDR, 32'h1);
        chk(active, 1'b1);
        @(posedge pclk);
        fuse <= 1'b1;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({active, force_an, sink, source}, 4'b0000);
        apb(1, ZCD_CONTROL_ADDR, 32'h11);
        apb(0, ZCD_STATUS_ADDR, 0);
        chk(rd, 32'h1);
        apb(1, ZCD_CONTROL_ADDR, 32'h80);
        chk({active, force_an, sink}, 3'b111);
        apb(1, ZCD_SYS_ADDR, 32'h1);
        chk(active, 1'b0);
        apb(1, ZCD_SYS_ADDR, 32'h0);
        chk(active, 1'b1);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // Clock, sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, fuse, above_req, sleep, slow} = 8'h00;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_regs();
        t_level();
        t_edges();
        t_clash();
        t_irq();
        t_fuse();
        give_verdict();
    end
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
endmodule
